/* include/bhib_pkg.sv */
// Notes on behaviour
// [R1] Programming interface byte reads fixed 00h.
// [R2] Sub-class 04h, base class 06h, fixed.
// [R3] Revision fixed by default; preload swaps two codes.
// [R4] Cache line size: read-write, resets 00h, inert.
// [R5] Latency timer byte reads 00h, ignores writes.
// [R6] Layout type field reads fixed 01h.
// [R7] Multi-function bit always reads 0.
// [R8] Self-test byte reads 00h always.
// [R9] Window space indicator bit hard-wired 0.
// [R10] Map type 00b/10b only, preloadable, read-only.
// [R11] Window prefetchable bit hard-wired 0.
// [R12] Prefetchable window read clears performance counter.
// [R13] Host reads counter by configuration when prefetchable.
// [R14] Window base address writable, resets to zero.
// [R15] Base words exist upstream only; else zero.
// [R16] 64-bit map: upper base word fully writable.
// [R17] 32-bit map: upper word zero, not loadable.
// [R18] Reserved-preserve bits read zero, ignore writes.
// [R19] Words decoded by offset, unused bits zero.
package bhib_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_CLASS_REV = 12'h008;
  localparam logic [11:0] OFS_MISC      = 12'h00C;
  localparam logic [11:0] OFS_BASE_LO   = 12'h010;
  localparam logic [11:0] OFS_BASE_HI   = 12'h014;

  // ------------------------------------------------------------------
  // Field values and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  PROG_IF_VAL    = 8'h00;
  localparam logic [7:0]  SUB_CLASS_VAL  = 8'h04;
  localparam logic [7:0]  BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0]  CACHE_RST      = 8'h00;
  localparam logic [7:0]  RSVD_BYTE      = 8'h00;
  localparam logic [6:0]  LAYOUT_VAL     = 7'h01;
  localparam logic        MULTI_FN_VAL   = 1'b0;
  localparam logic        MEM_IND_VAL    = 1'b0;
  localparam logic        PREFETCH_VAL   = 1'b0;
  localparam logic [1:0]  MAP_32         = 2'b00;
  localparam logic [1:0]  MAP_64         = 2'b10;
  localparam logic [31:0] BASE_RST       = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int REV_LSB    = 0;
  localparam int PROG_LSB   = 8;
  localparam int SUB_LSB    = 16;
  localparam int CLS_LSB    = 24;
  localparam int CACHE_LSB  = 0;
  localparam int LAT_LSB    = 8;
  localparam int LAYOUT_LSB = 16;
  localparam int MULTI_BIT  = 23;
  localparam int SELF_LSB   = 24;
  localparam int MEMIND_BIT = 0;
  localparam int MAP_LSB    = 1;
  localparam int PREF_BIT   = 3;

  // ------------------------------------------------------------------
  // Word selector
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    BHIB_SEL_NONE  = 3'h0,
    BHIB_SEL_CLASS = 3'h1,
    BHIB_SEL_MISC  = 3'h3,
    BHIB_SEL_LO    = 3'h2,
    BHIB_SEL_HI    = 3'h6
  } bhib_sel_t;

endpackage

/* verilog/bhib_strap_sync.sv */
`timescale 1ns/1ps
module bhib_strap_sync import bhib_pkg::*; (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // ------------------------------------------------------------------
  // Three-stage capture, change accepted when stages two and three agree
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level_out = lvl_q;

endmodule // bhib_strap_sync

/* verilog/bhib_hdr_regs.sv */
`timescale 1ns/1ps
module bhib_hdr_regs import bhib_pkg::*; #(
  parameter int         WIN_LSB     = 12,
  parameter logic [7:0] REV_DEFAULT = 8'h01, // Arbitrary value
  parameter logic [7:0] REV_CODE_A  = 8'h11, // Arbitrary value
  parameter logic [7:0] REV_CODE_B  = 8'h22  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Port role strap pin
  input  wire logic        upstream_strap,
  // Register request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_mem,
  input  wire logic        req_prefetch,
  input  wire logic [11:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_be,
  // Preload from serial memory or two-wire bus
  input  wire logic        ld_valid,
  input  wire logic [11:0] ld_addr,
  input  wire logic [31:0] ld_data,
  // Answer
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  // Side effects and state
  output logic             perf_clear,
  output logic [63:0]      window_base,
  output logic             window_is_64,
  output logic             is_upstream
);

  localparam int LO_W = 32 - WIN_LSB;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Offset decode shared by requests and preload
  function automatic bhib_sel_t sel_of(input logic [11:0] a);
    case ({a[11:2], 2'b00})
      OFS_CLASS_REV: sel_of = BHIB_SEL_CLASS;
      OFS_MISC:      sel_of = BHIB_SEL_MISC;
      OFS_BASE_LO:   sel_of = BHIB_SEL_LO;
      OFS_BASE_HI:   sel_of = BHIB_SEL_HI;
      default:       sel_of = BHIB_SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Revision code swap on preload
  function automatic logic [7:0] rev_swap(input logic [7:0] v);
    if (v == REV_CODE_A) begin
      rev_swap = REV_CODE_B;
    end else if (v == REV_CODE_B) begin
      rev_swap = REV_CODE_A;
    end else begin
      rev_swap = v;
    end
  endfunction

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic             up_lvl;
  logic             up_q;
  logic [7:0]       rev_q;
  logic [7:0]       cache_q;
  logic [1:0]       map_q;
  logic [LO_W-1:0]  base_lo_q;
  logic [31:0]      base_hi_q;
  logic             rsp_valid_q;
  logic [31:0]      rsp_rdata_q;
  logic             perf_clear_q;
  logic [63:0]      window_base_q;
  logic             window_is_64_q;
  bhib_sel_t        req_sel;
  bhib_sel_t        ld_sel;
  logic             wr_go;
  logic             is64;
  logic [31:0]      lo_word;
  logic [31:0]      lo_wr;
  logic [31:0]      rd_word;

  // ------------------------------------------------------------------
  // Port role
  // ------------------------------------------------------------------
  bhib_strap_sync u_strap (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pin_in    (upstream_strap),
    .level_out (up_lvl)
  );

  // Role register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      up_q <= 1'b0;
    end else begin
      up_q <= up_lvl;
    end
  end

  // ------------------------------------------------------------------
  // Decode; preload wins over a software write in the same cycle
  // ------------------------------------------------------------------
  assign req_sel = sel_of(req_addr);
  assign ld_sel  = sel_of(ld_addr);
  assign wr_go   = req_valid & req_write & ~ld_valid;
  assign is64    = (map_q == MAP_64);
  assign lo_word = {base_lo_q, {WIN_LSB{1'b0}}};
  assign lo_wr   = merge(lo_word, req_wdata, req_be);

  // ------------------------------------------------------------------
  // Revision, preload only
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rev_q <= REV_DEFAULT;
    end else if (ld_valid && ld_sel == BHIB_SEL_CLASS) begin
      rev_q <= rev_swap(ld_data[REV_LSB +: 8]); // R3
    end
  end

  // ------------------------------------------------------------------
  // Cache line size
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cache_q <= CACHE_RST;
    end else if (ld_valid && ld_sel == BHIB_SEL_MISC) begin
      cache_q <= ld_data[CACHE_LSB +: 8]; // R4
    end else if (wr_go && req_sel == BHIB_SEL_MISC && req_be[0]) begin
      cache_q <= req_wdata[CACHE_LSB +: 8]; // R4
    end
  end

  // ------------------------------------------------------------------
  // Map type, preload only, reserved codes refused
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      map_q <= MAP_32;
    end else if (ld_valid && ld_sel == BHIB_SEL_LO && up_q &&
                 (ld_data[MAP_LSB +: 2] == MAP_32 ||
                  ld_data[MAP_LSB +: 2] == MAP_64)) begin
      map_q <= ld_data[MAP_LSB +: 2]; // R10
    end
  end

  // ------------------------------------------------------------------
  // Lower window base
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base_lo_q <= BASE_RST[31:WIN_LSB]; // R14
    end else if (!up_q) begin
      base_lo_q <= BASE_RST[31:WIN_LSB]; // R15
    end else if (ld_valid && ld_sel == BHIB_SEL_LO) begin
      base_lo_q <= ld_data[31:WIN_LSB];
    end else if (wr_go && req_sel == BHIB_SEL_LO) begin
      base_lo_q <= lo_wr[31:WIN_LSB]; // R14
    end
  end

  // ------------------------------------------------------------------
  // Upper window base, live only with 64-bit map
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base_hi_q <= BASE_RST;
    end else if (!up_q || !is64) begin
      base_hi_q <= BASE_RST; // R15 R17
    end else if (ld_valid && ld_sel == BHIB_SEL_HI) begin
      base_hi_q <= ld_data; // R16
    end else if (wr_go && req_sel == BHIB_SEL_HI) begin
      base_hi_q <= merge(base_hi_q, req_wdata, req_be); // R16
    end
  end

  // ------------------------------------------------------------------
  // Read word assembly; unlisted positions read zero
  // ------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000; // R19
    case (req_sel)
      BHIB_SEL_CLASS: begin
        rd_word[REV_LSB  +: 8] = rev_q; // R3
        rd_word[PROG_LSB +: 8] = PROG_IF_VAL; // R1
        rd_word[SUB_LSB  +: 8] = SUB_CLASS_VAL; // R2
        rd_word[CLS_LSB  +: 8] = BASE_CLASS_VAL; // R2
      end
      BHIB_SEL_MISC: begin
        rd_word[CACHE_LSB  +: 8] = cache_q; // R4
        rd_word[LAT_LSB    +: 8] = RSVD_BYTE; // R5 R18
        rd_word[LAYOUT_LSB +: 7] = LAYOUT_VAL; // R6
        rd_word[MULTI_BIT]       = MULTI_FN_VAL; // R7
        rd_word[SELF_LSB   +: 8] = RSVD_BYTE; // R8
      end
      BHIB_SEL_LO: begin
        if (up_q) begin
          rd_word              = lo_word; // R14
          rd_word[MEMIND_BIT]  = MEM_IND_VAL; // R9
          rd_word[MAP_LSB +: 2] = map_q; // R10
          rd_word[PREF_BIT]    = PREFETCH_VAL; // R11
        end
      end
      BHIB_SEL_HI: begin
        if (up_q && is64) begin
          rd_word = base_hi_q; // R16
        end
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Answer, one cycle after each request
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= req_valid;
      rsp_rdata_q <= (req_valid && !req_write) ? rd_word : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Counter clear on prefetchable window read, any byte enables
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      perf_clear_q <= 1'b0;
    end else begin
      perf_clear_q <= req_valid & ~req_write & req_mem & req_prefetch & up_q; // R12
    end
  end

  // ------------------------------------------------------------------
  // Window position for the memory decoder
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      window_base_q  <= 64'h0000_0000_0000_0000;
      window_is_64_q <= 1'b0;
    end else begin
      window_base_q  <= {base_hi_q, lo_word}; // R14 R16
      window_is_64_q <= is64 & up_q;
    end
  end

  assign rsp_valid    = rsp_valid_q;
  assign rsp_rdata    = rsp_rdata_q;
  assign perf_clear   = perf_clear_q;
  assign window_base  = window_base_q;
  assign window_is_64 = window_is_64_q;
  assign is_upstream  = up_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [7:0] cache_seen_q;

  // Last cache value written by software
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cache_seen_q <= 8'h00;
    end else if (wr_go && req_sel == BHIB_SEL_MISC && req_be[0]) begin
      cache_seen_q <= req_wdata[7:0];
    end
  end

  sequence s_rd(bhib_sel_t s);
    req_valid && !req_write && req_sel == s;
  endsequence

  sequence s_cache_wr;
    wr_go && req_sel == BHIB_SEL_MISC && req_be[0];
  endsequence

  sequence s_quiet_rd_misc;
    !ld_valid && req_valid && !req_write && req_sel == BHIB_SEL_MISC;
  endsequence

  a_rsp_timing: assert property (req_valid |=> rsp_valid ##0 $past(req_valid)) // R19
    else $error("answer missing one cycle after request");

  a_class_word: assert property (s_rd(BHIB_SEL_CLASS) |=>
      rsp_rdata[31:8] == {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL}) // R1 R2
    else $error("class code word wrong");

  a_misc_fixed: assert property (s_rd(BHIB_SEL_MISC) |=>
      rsp_rdata[31:8] == {RSVD_BYTE, MULTI_FN_VAL, LAYOUT_VAL, RSVD_BYTE}) // R5 R6 R7 R8
    else $error("misc control fixed fields wrong");

  a_cache_rw: assert property (s_cache_wr ##1 (!ld_valid && !req_valid) ##1 s_quiet_rd_misc |=>
      rsp_rdata[7:0] == cache_seen_q) // R4
    else $error("cache line size not kept");

  a_bar_flags: assert property (s_rd(BHIB_SEL_LO) |=>
      !rsp_rdata[0] && !rsp_rdata[3] && rsp_rdata[2:1] != 2'b01 &&
      rsp_rdata[2:1] != 2'b11) // R9 R10 R11
    else $error("window flag bits wrong");

  a_perf_clear: assert property (perf_clear == $past(req_valid && !req_write &&
      req_mem && req_prefetch && up_q)) // R12
    else $error("counter clear pulse wrong");

  a_hi_zero32: assert property (req_valid && !req_write && req_sel == BHIB_SEL_HI && !is64
      |=> rsp_rdata == 32'h0) // R17
    else $error("upper word not zero in 32-bit map");

  a_down_zero: assert property (req_valid && !req_write && !up_q &&
      (req_sel == BHIB_SEL_LO || req_sel == BHIB_SEL_HI) |=> rsp_rdata == 32'h0) // R15
    else $error("downstream base word not zero");

  a_rev_swap: assert property (ld_valid && ld_sel == BHIB_SEL_CLASS &&
      ld_data[7:0] == REV_CODE_A |=> rev_q == REV_CODE_B) // R3
    else $error("revision preload not swapped");

endmodule // bhib_hdr_regs

/* bench/bhib_host_model.sv */
`timescale 1ns/1ps
module bhib_host_model (
  // Clock
  input  wire logic        core_clk,
  // Request lines
  output logic             req_valid,
  output logic             req_write,
  output logic             req_mem,
  output logic             req_prefetch,
  output logic [11:0]      req_addr,
  output logic [31:0]      req_wdata,
  output logic [3:0]       req_be,
  // Preload lines
  output logic             ld_valid,
  output logic [11:0]      ld_addr,
  output logic [31:0]      ld_data,
  // Answer
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  input  wire logic        perf_clear
);
  // ------------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------------
  initial begin
    req_valid    = 1'h0;
    req_write    = 1'h0;
    req_mem      = 1'h0;
    req_prefetch = 1'h0;
    req_addr     = 12'h000;
    req_wdata    = 32'h0;
    req_be       = 4'h0;
    ld_valid     = 1'h0;
    ld_addr      = 12'h000;
    ld_data      = 32'h0;
  end

  // One request, answer taken one cycle later
  task automatic access(input logic wr, input logic mem, input logic pf,
                        input logic [11:0] addr, input logic [31:0] wd,
                        input logic [3:0] be, output logic [31:0] rd,
                        output logic pc, output logic rv);
    @(posedge core_clk);
    req_valid    <= 1'h1;
    req_write    <= wr;
    req_mem      <= mem;
    req_prefetch <= pf;
    req_addr     <= addr;
    req_wdata    <= wd;
    req_be       <= be;
    @(posedge core_clk);
    // Released address, data and byte-enable lines show inverted data, not the last value
    req_valid    <= 1'h0;
    req_addr     <= ~addr;
    req_wdata    <= ~wd;
    req_be       <= ~be;
    #1;
    rd = rsp_rdata;
    pc = perf_clear;
    rv = rsp_valid;
  endtask

  // One preload word
  task automatic load(input logic [11:0] addr, input logic [31:0] d);
    @(posedge core_clk);
    ld_valid <= 1'h1;
    ld_addr  <= addr;
    ld_data  <= d;
    @(posedge core_clk);
    ld_valid <= 1'h0;
    ld_data  <= ~d;
  endtask

  // Read-modify-write by configuration, reserved bits written back as read
  task automatic modify(input logic [11:0] addr, input logic [31:0] mask,
                        input logic [31:0] val);
    logic [31:0] d;
    logic        pc;
    logic        rv;
    access(1'h0, 1'h0, 1'h0, addr, 32'h0, 4'hF, d, pc, rv);
    access(1'h1, 1'h0, 1'h0, addr, (d & ~mask) | (val & mask), 4'hF, d, pc, rv);
  endtask
endmodule // bhib_host_model

/* bench/bhib_hdr_regs_tb.sv */
`timescale 1ns/1ps
module bhib_hdr_regs_tb import bhib_pkg::*; ();
  // ------------------------------------------------------------------
  // Settings and wiring
  // ------------------------------------------------------------------
  localparam logic [7:0] REV_DEF = 8'h01; // Arbitrary value
  localparam logic [7:0] REV_A   = 8'h11; // Arbitrary value
  localparam logic [7:0] REV_B   = 8'h22; // Arbitrary value
  localparam int         TIMEOUT = 4000;

  logic        core_clk, rstn, upstream_strap;
  logic        req_valid, req_write, req_mem, req_prefetch, ld_valid;
  logic [11:0] req_addr, ld_addr;
  logic [31:0] req_wdata, ld_data, rsp_rdata;
  logic [3:0]  req_be;
  logic        rsp_valid, perf_clear, window_is_64, is_upstream;
  logic [63:0] window_base;
  logic [7:0]  rev_in [3] = '{REV_A, REV_B, 8'h5C};
  logic [7:0]  rev_out [3] = '{REV_B, REV_A, 8'h5C};
  int          miscompares, total_checks;
  int          cycles = 0;

  bhib_hdr_regs #(.WIN_LSB(12), .REV_DEFAULT(REV_DEF), .REV_CODE_A(REV_A),
                  .REV_CODE_B(REV_B)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .upstream_strap(upstream_strap),
    .req_valid(req_valid), .req_write(req_write), .req_mem(req_mem),
    .req_prefetch(req_prefetch), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_be(req_be), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .perf_clear(perf_clear),
    .window_base(window_base), .window_is_64(window_is_64), .is_upstream(is_upstream));

  bhib_host_model u_host (
    .core_clk(core_clk), .req_valid(req_valid), .req_write(req_write),
    .req_mem(req_mem), .req_prefetch(req_prefetch), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .ld_valid(ld_valid), .ld_addr(ld_addr),
    .ld_data(ld_data), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .perf_clear(perf_clear));

  // ------------------------------------------------------------------
  // Clock, watchdog and helpers
  // ------------------------------------------------------------------
  always #2 core_clk = ~core_clk;

  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Configuration request with answer checks
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    logic pc;
    logic rv;
    u_host.access(wr, 1'h0, 1'h0, a, wd, be, rd, pc, rv);
    check(rv, 1'h1);
    check(pc, 1'h0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    cfg(1'h0, a, 32'h0, 4'hF, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    cfg(1'h1, a, wd, be, d);
    check(d, 32'h0);
  endtask

  // Window read, perf clear expected or not
  task automatic mem_rd(input logic pf, input logic [3:0] be, input logic exp_pc);
    logic [31:0] d;
    logic        pc;
    logic        rv;
    u_host.access(1'h0, 1'h1, pf, OFS_MISC, 32'h0, be, d, pc, rv);
    check(rv, 1'h1);
    check(pc, exp_pc);
  endtask

  task automatic reset_dut(input logic up);
    @(posedge core_clk);
    upstream_strap <= up;
    rstn           <= 1'h0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (10) @(posedge core_clk);
    #1;
    check(is_upstream, up);
  endtask

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk       = 1'h0;
    rstn           = 1'h0;
    upstream_strap = 1'h1;
    miscompares    = 0;
    total_checks   = 0;
    reset_dut(1'h1);
    // Fixed identity word and revision default
    rd_chk(OFS_CLASS_REV, {8'h06, 8'h04, 8'h00, REV_DEF});
    wr(OFS_CLASS_REV, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_CLASS_REV, {8'h06, 8'h04, 8'h00, REV_DEF});
    // Miscellaneous control word
    rd_chk(OFS_MISC, 32'h0001_0000);
    wr(OFS_MISC, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_MISC, 32'h0001_00FF);
    wr(OFS_MISC, 32'h0000_0000, 4'hE);
    rd_chk(OFS_MISC, 32'h0001_00FF);
    u_host.modify(OFS_MISC, 32'h0000_00FF, 32'h0000_005A);
    rd_chk(OFS_MISC, 32'h0001_005A);
    u_host.load(OFS_MISC, 32'h0000_00C3);
    rd_chk(OFS_MISC, 32'h0001_00C3);
    // Lower base word, 32-bit map
    rd_chk(OFS_BASE_LO, 32'h0);
    wr(OFS_BASE_LO, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_BASE_LO, 32'hFFFF_F000);
    wr(OFS_BASE_LO, 32'h0000_0000, 4'h8);
    rd_chk(OFS_BASE_LO, 32'h00FF_F000);
    check(window_base, 64'h0000_0000_00FF_F000);
    wr(OFS_BASE_HI, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_BASE_HI, 32'h0);
    check(window_is_64, 1'h0);
    // Performance counter clear on window reads
    for (int i = 0; i < 16; i += 5) begin
      mem_rd(1'h1, 4'(i), 1'h1);
    end
    mem_rd(1'h0, 4'hF, 1'h0);
    // Preloaded 64-bit map and upper word
    u_host.load(OFS_BASE_LO, 32'h1234_5004);
    rd_chk(OFS_BASE_LO, 32'h1234_5004);
    u_host.load(OFS_BASE_HI, 32'hABCD_EF01);
    rd_chk(OFS_BASE_HI, 32'hABCD_EF01);
    wr(OFS_BASE_HI, 32'h0000_00FF, 4'h1);
    rd_chk(OFS_BASE_HI, 32'hABCD_EFFF);
    check(window_is_64, 1'h1);
    check(window_base, 64'hABCD_EFFF_1234_5000);
    for (int m = 1; m < 4; m += 2) begin
      u_host.load(OFS_BASE_LO, 32'h1234_5000 + 32'(m * 2));
      rd_chk(OFS_BASE_LO, 32'h1234_5004);
    end
    u_host.load(OFS_BASE_LO, 32'h1234_5000);
    rd_chk(OFS_BASE_HI, 32'h0);
    u_host.load(OFS_BASE_HI, 32'h5555_5555);
    rd_chk(OFS_BASE_HI, 32'h0);
    // Revision preload swap
    for (int i = 0; i < 3; i++) begin
      u_host.load(OFS_CLASS_REV, {24'h0, rev_in[i]});
      rd_chk(OFS_CLASS_REV, {24'h06_0400, rev_out[i]});
    end
    // Unmapped offsets and ignored low address bits
    wr(12'h040, 32'hFFFF_FFFF, 4'hF);
    rd_chk(12'h040, 32'h0);
    rd_chk(12'h00E, 32'h0001_00C3);
    // Downstream port
    reset_dut(1'h0);
    wr(OFS_BASE_LO, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_BASE_LO, 32'h0);
    u_host.load(OFS_BASE_LO, 32'h1234_5004);
    rd_chk(OFS_BASE_LO, 32'h0);
    rd_chk(OFS_BASE_HI, 32'h0);
    check(window_base, 64'h0);
    rd_chk(OFS_MISC, 32'h0001_0000);
    rd_chk(OFS_CLASS_REV, {8'h06, 8'h04, 8'h00, REV_DEF});
    mem_rd(1'h1, 4'hF, 1'h0);
    conclude();
  end
endmodule // bhib_hdr_regs_tb
